//--- include/cmrf_pkg.sv
package cmrf_pkg;
  // ----------------------------------------------------------------
  // Fabric dimensions
  // ----------------------------------------------------------------
  localparam int NUM_MC = 32; // Macrocells
  localparam int PT_PER_MC = 5; // Product terms per macrocell
  localparam int NUM_DED = 4; // Dedicated input pins
  localparam int NUM_IO = 32; // I/O pins
  localparam int GBUS_W = NUM_MC + NUM_DED + NUM_IO; // Global bus width
  localparam int NUM_LB = 2; // Logic blocks
  localparam int MC_PER_LB = 16; // Macrocells per logic block
  localparam int SW_SEL = 40; // Signals picked per switch matrix
  localparam int SEL_W = 7; // Width of one switch selector
  localparam int REGION = 4; // Macrocells sharing a regional bus
  localparam int CHAIN_LEN = 8; // Macrocells in one cascade chain
  localparam int PT_IN_W = SW_SEL + REGION; // Inputs of one product term
  localparam int SIG_W = 16; // User signature width
  // ----------------------------------------------------------------
  // Configuration rows
  // ----------------------------------------------------------------
  localparam int ROW_W = 96; // Width of one configuration row
  localparam int ADDR_W = 9; // Row address width
  localparam int ROW_PT_BASE = 0; // Product term rows, mc*5+pt
  localparam int ROW_CTL_BASE = 160; // Macrocell control rows
  localparam int ROW_SW_BASE = 192; // Switch rows, lb*40+slot
  localparam int CFG_ROWS = 272; // Rows in total
  localparam int PT_USED_BIT = 88; // Product term in use
  // Fixed product term duties in the allocator
  localparam int PT_AP = 0;
  localparam int PT_AR = 1;
  localparam int PT_CLK = 2;
  localparam int PT_CE = 3;
  localparam int PT_AUX = 4; // XOR input or output enable
  localparam logic [1:0] XOR_ZERO = 2'h0;
  localparam logic [1:0] XOR_ONE = 2'h1;
  localparam logic [2:0] CLK_FROM_PT = 3'h4;
  localparam logic [1:0] OE_OFF = 2'h0;
  localparam logic [1:0] OE_ON = 2'h1;
  localparam logic [1:0] OE_PIN = 2'h2;
  // ----------------------------------------------------------------
  // Test access port
  // ----------------------------------------------------------------
  localparam int IR_W = 4;
  localparam logic [3:0] IR_CFG_ADDR = 4'h1;
  localparam logic [3:0] IR_CFG_DATA = 4'h2;
  localparam logic [3:0] IR_SIG = 4'h3;
  localparam logic [3:0] IR_FUSE = 4'h4;
  localparam logic [3:0] IR_ERASE = 4'h5;
  localparam logic [3:0] IR_BYPASS = 4'hF;
  localparam logic [3:0] IR_CAPTURE = 4'h1;

  typedef enum logic [3:0] {
    TAP_TLR, TAP_RTI, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EX1_DR, TAP_PAUSE_DR,
    TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR, TAP_EX1_IR,
    TAP_PAUSE_IR, TAP_EX2_IR, TAP_UPD_IR
  } cmrf_tap_t;

  // Per-macrocell control row, low bits of the row
  typedef struct packed {
    logic [4:0] or_mask; // Terms steered to the OR gate
    logic [1:0] xor_src; // Zero, one, or the aux term
    logic ce_en; // Clock enable from its term
    logic [2:0] clk_sel; // Pin 0..3 or its term
    logic [1:0] ar_mode; // Bit0 clear pin, bit1 term
    logic [1:0] clr_pin; // Pin used as clear
    logic ap_en; // Preset from its term
    logic [2:0] fold_sel; // Term folded back inverted
    logic cas_en; // Take the cascade from below
    logic latch; // Flow-through latch mode
    logic comb_out; // Output bypasses the register
    logic [1:0] oe_mode; // Off, on, pin, aux term
    logic [1:0] oe_pin; // Pin used as output enable
  } cmrf_mc_ctl_t;
  localparam int MC_CTL_W = $bits(cmrf_mc_ctl_t);

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } cmrf_jtag_t;

  typedef struct packed {
    logic [NUM_DED-1:0] ded; // Dedicated inputs, 0..3 selectable as clocks
    logic [NUM_IO-1:0] io_in; // Pin levels of the I/O pins
  } cmrf_pins_t;

  typedef struct packed {
    logic [CFG_ROWS-1:0][ROW_W-1:0] cfg; // Configuration store
    logic [SIG_W-1:0] sig; // User signature
    logic fuse; // Security fuse
    cmrf_tap_t tap;
    logic [IR_W-1:0] ir;
    logic [ADDR_W-1:0] addr;
    logic [ROW_W-1:0] dr; // Shared shift register
    logic tck_prev;
    logic tdo;
    logic tdo_oe_n;
    logic [NUM_MC-1:0] mc_q; // Macrocell registers
    logic [NUM_MC-1:0] clk_prev; // Last level of each chosen clock
    logic [NUM_MC-1:0] fold; // Regional foldback terms
    logic [NUM_IO-1:0] io_out;
    logic [NUM_IO-1:0] io_oe_n;
  } cmrf_state_t;
endpackage

//--- core/cmrf_fabric.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Feedbacks and all pins feed global bus
// - Each switch matrix picks 40 bus signals
// - Each macrocell puts foldback on regional bus
// - Four cascade chains reach 40 product terms
// - Five product terms see global and regional
// - Allocator steers terms to gates or controls
// - Dedicated pins selectable as clock, clear, enable
// - Programmed fuse blocks configuration readout
// - Signature readable and writable despite fuse
// - Configuration loads through four-pin test port
// - Flip-flop changes on rising clock edge only
// - Clock enable low ignores clock edges
// - Latch passes while clock high, holds low
module cmrf_fabric (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Test access port
  input cmrf_pkg::cmrf_jtag_t jtag,
  output logic tdo,
  output logic tdo_oe_n,
  // Device pins
  input cmrf_pkg::cmrf_pins_t pins,
  output logic [cmrf_pkg::NUM_IO-1:0] io_out,
  output logic [cmrf_pkg::NUM_IO-1:0] io_oe_n
);
  import cmrf_pkg::*;

  cmrf_state_t s_q; // All state
  cmrf_state_t s_d; // Its next value
  logic [GBUS_W-1:0] gbus; // Global bus
  logic [NUM_LB-1:0][SW_SEL-1:0] sw; // Switch matrix outputs
  logic [NUM_MC-1:0][PT_PER_MC-1:0] pt; // Product terms
  cmrf_mc_ctl_t [NUM_MC-1:0] ctl; // Decoded control rows
  logic [NUM_MC-1:0] sum; // OR plus cascade
  logic [NUM_MC-1:0] xr; // XOR result
  logic [NUM_MC-1:0] mclk; // Chosen clock
  logic [NUM_MC-1:0] ce_ok; // Clock enable satisfied
  logic [NUM_MC-1:0] ar; // Reset active
  logic [NUM_MC-1:0] ap; // Preset active
  logic tck_rise; // Test clock edges
  logic tck_fall;
  int dr_len; // Active shift length

  // ----------------------------------------------------------------
  // Logic fabric and test access port
  // ----------------------------------------------------------------
  // Feedback is the register only: a combinational path through the
  // bus would form a loop, so buried feedback is always registered.
  always_comb begin
    logic [PT_IN_W-1:0] ins;
    logic [ROW_W-1:0] row;
    logic [SEL_W-1:0] sel;
    logic xin;
    ins = '0;
    row = '0;
    sel = '0;
    xin = 1'b0;
    s_d = s_q;
    gbus = {pins.io_in, pins.ded, s_q.mc_q};
    // Switch matrices, out of range selectors give zero
    for (int b = 0; b < NUM_LB; b++) begin
      for (int k = 0; k < SW_SEL; k++) begin
        sel = s_q.cfg[ROW_SW_BASE + b * SW_SEL + k][SEL_W-1:0];
        sw[b][k] = (sel < GBUS_W) ? gbus[sel] : 1'b0;
      end
    end
    for (int m = 0; m < NUM_MC; m++) begin
      ctl[m] = cmrf_mc_ctl_t'(s_q.cfg[ROW_CTL_BASE + m][MC_CTL_W-1:0]);
      ins = {s_q.fold[(m / REGION) * REGION +: REGION], sw[m / MC_PER_LB]};
      // Product terms: low half true mask, high half complement mask
      for (int p = 0; p < PT_PER_MC; p++) begin
        row = s_q.cfg[ROW_PT_BASE + m * PT_PER_MC + p];
        pt[m][p] = (&(~row[PT_IN_W-1:0] | ins)) & (&(~row[2*PT_IN_W-1:PT_IN_W] | ~ins));
        pt[m][p] = pt[m][p] & row[PT_USED_BIT];
      end
      // Sum term, chained within groups of eight
      sum[m] = |(pt[m] & ctl[m].or_mask);
      if (ctl[m].cas_en && (m % CHAIN_LEN) != 0) begin
        sum[m] = sum[m] | sum[m-1];
      end
      // XOR fixed level or aux term, selects polarity
      if (ctl[m].xor_src == XOR_ZERO) begin
        xin = 1'b0;
      end else if (ctl[m].xor_src == XOR_ONE) begin
        xin = 1'b1;
      end else begin
        xin = pt[m][PT_AUX];
      end
      xr[m] = sum[m] ^ xin;
      // Register controls from pins or terms
      mclk[m] = (ctl[m].clk_sel == CLK_FROM_PT) ? pt[m][PT_CLK] :
                pins.ded[ctl[m].clk_sel[1:0]];
      ce_ok[m] = !ctl[m].ce_en || pt[m][PT_CE];
      ar[m] = (ctl[m].ar_mode[0] & pins.ded[ctl[m].clr_pin]) |
              (ctl[m].ar_mode[1] & pt[m][PT_AR]);
      ap[m] = ctl[m].ap_en & pt[m][PT_AP];
      // Register, clear wins over preset
      if (ar[m]) begin
        s_d.mc_q[m] = 1'b0;
      end else if (ap[m]) begin
        s_d.mc_q[m] = 1'b1;
      end else if (ctl[m].latch) begin
        if (mclk[m]) begin
          s_d.mc_q[m] = xr[m];
        end
      end else if (mclk[m] && !s_q.clk_prev[m] && ce_ok[m]) begin
        s_d.mc_q[m] = xr[m];
      end
      s_d.clk_prev[m] = mclk[m];
      // Foldback is registered to break the regional loop
      s_d.fold[m] = (ctl[m].fold_sel < PT_PER_MC) ? !pt[m][ctl[m].fold_sel] : 1'b0;
      s_d.io_out[m] = ctl[m].comb_out ? xr[m] : s_q.mc_q[m];
      // Output enable, pin low while driving
      unique case (ctl[m].oe_mode)
        OE_OFF: s_d.io_oe_n[m] = 1'b1;
        OE_ON: s_d.io_oe_n[m] = 1'b0;
        OE_PIN: s_d.io_oe_n[m] = !pins.ded[ctl[m].oe_pin];
        default: s_d.io_oe_n[m] = !pt[m][PT_AUX];
      endcase
    end
    // Test clock sampled as a plain input
    tck_rise = jtag.tck && !s_q.tck_prev;
    tck_fall = !jtag.tck && s_q.tck_prev;
    s_d.tck_prev = jtag.tck;
    // Shift length per instruction
    if (s_q.tap == TAP_SHIFT_IR) begin
      dr_len = IR_W;
    end else if (s_q.ir == IR_CFG_ADDR) begin
      dr_len = ADDR_W;
    end else if (s_q.ir == IR_CFG_DATA) begin
      dr_len = ROW_W;
    end else if (s_q.ir == IR_SIG) begin
      dr_len = SIG_W;
    end else begin
      dr_len = 1;
    end
    if (tck_rise) begin
      // Action of the state being left
      unique case (s_q.tap)
        TAP_TLR: s_d.ir = IR_BYPASS;
        TAP_CAP_IR: s_d.dr = ROW_W'(IR_CAPTURE);
        TAP_UPD_IR: s_d.ir = s_q.dr[IR_W-1:0];
        TAP_SHIFT_DR, TAP_SHIFT_IR: begin
          s_d.dr = {1'b0, s_q.dr[ROW_W-1:1]};
          s_d.dr[dr_len-1] = jtag.tdi;
        end
        TAP_CAP_DR: begin
          s_d.dr = '0;
          if (s_q.ir == IR_CFG_ADDR) begin
            s_d.dr[ADDR_W-1:0] = s_q.addr;
          end else if (s_q.ir == IR_CFG_DATA && !s_q.fuse && s_q.addr < CFG_ROWS) begin
            s_d.dr = s_q.cfg[s_q.addr];
          end else if (s_q.ir == IR_SIG) begin
            s_d.dr[SIG_W-1:0] = s_q.sig;
          end else if (s_q.ir == IR_FUSE) begin
            s_d.dr[0] = s_q.fuse;
          end
        end
        TAP_UPD_DR: begin
          if (s_q.ir == IR_CFG_ADDR) begin
            s_d.addr = s_q.dr[ADDR_W-1:0];
          end else if (s_q.ir == IR_CFG_DATA && s_q.addr < CFG_ROWS) begin
            s_d.cfg[s_q.addr] = s_q.dr;
          end else if (s_q.ir == IR_SIG) begin
            s_d.sig = s_q.dr[SIG_W-1:0];
          end else if (s_q.ir == IR_FUSE && s_q.dr[0]) begin
            s_d.fuse = 1'b1;
          end else if (s_q.ir == IR_ERASE) begin
            s_d.cfg = '0;
            s_d.fuse = 1'b0;
          end
        end
        default: s_d.ir = s_q.ir;
      endcase
      // Standard state transitions
      unique case (s_q.tap)
        TAP_TLR: s_d.tap = jtag.tms ? TAP_TLR : TAP_RTI;
        TAP_RTI: s_d.tap = jtag.tms ? TAP_SEL_DR : TAP_RTI;
        TAP_SEL_DR: s_d.tap = jtag.tms ? TAP_SEL_IR : TAP_CAP_DR;
        TAP_CAP_DR: s_d.tap = jtag.tms ? TAP_EX1_DR : TAP_SHIFT_DR;
        TAP_SHIFT_DR: s_d.tap = jtag.tms ? TAP_EX1_DR : TAP_SHIFT_DR;
        TAP_EX1_DR: s_d.tap = jtag.tms ? TAP_UPD_DR : TAP_PAUSE_DR;
        TAP_PAUSE_DR: s_d.tap = jtag.tms ? TAP_EX2_DR : TAP_PAUSE_DR;
        TAP_EX2_DR: s_d.tap = jtag.tms ? TAP_UPD_DR : TAP_SHIFT_DR;
        TAP_UPD_DR: s_d.tap = jtag.tms ? TAP_SEL_DR : TAP_RTI;
        TAP_SEL_IR: s_d.tap = jtag.tms ? TAP_TLR : TAP_CAP_IR;
        TAP_CAP_IR: s_d.tap = jtag.tms ? TAP_EX1_IR : TAP_SHIFT_IR;
        TAP_SHIFT_IR: s_d.tap = jtag.tms ? TAP_EX1_IR : TAP_SHIFT_IR;
        TAP_EX1_IR: s_d.tap = jtag.tms ? TAP_UPD_IR : TAP_PAUSE_IR;
        TAP_PAUSE_IR: s_d.tap = jtag.tms ? TAP_EX2_IR : TAP_PAUSE_IR;
        TAP_EX2_IR: s_d.tap = jtag.tms ? TAP_UPD_IR : TAP_SHIFT_IR;
        TAP_UPD_IR: s_d.tap = jtag.tms ? TAP_SEL_DR : TAP_RTI;
      endcase
    end
    // Test data out changes on the falling edge
    if (tck_fall) begin
      s_d.tdo = s_q.dr[0];
      s_d.tdo_oe_n = !(s_q.tap == TAP_SHIFT_DR || s_q.tap == TAP_SHIFT_IR);
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Configuration is cleared by reset; a real part keeps it across power
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
      s_q.ir <= IR_BYPASS;
      s_q.tdo_oe_n <= 1'b1;
      s_q.io_oe_n <= '1;
    end else begin
      s_q <= s_d;
    end
  end

  assign tdo = s_q.tdo;
  assign tdo_oe_n = s_q.tdo_oe_n;
  assign io_out = s_q.io_out;
  assign io_oe_n = s_q.io_oe_n;

  // ----------------------------------------------------------------
  // Checks on macrocells 0 and 1 and the port
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  logic [SEL_W-1:0] sel0;
  assign sel0 = s_q.cfg[ROW_SW_BASE][SEL_W-1:0];
  a_fb_on_bus: assert property (sel0 == 7'h00 |-> sw[0][0] == s_q.mc_q[0])
    else $error("feedback not on bus");
  a_pin_routed: assert property (sel0 == 7'h24 |-> sw[0][0] == pins.io_in[0])
    else $error("pin not routed");
  a_unused_term: assert property (!s_q.cfg[0][PT_USED_BIT] |-> !pt[0][0])
    else $error("unused term active");
  a_fold_inverse: assert property (ctl[0].fold_sel == 3'h0
    |=> s_q.fold[0] == !$past(pt[0][0]))
    else $error("foldback wrong");
  a_cascade_join: assert property (ctl[1].cas_en && sum[0] |-> sum[1])
    else $error("cascade lost");
  a_ff_edge_only: assert property (!ar[0] && !ap[0] && !ctl[0].latch
    && !(mclk[0] && !s_q.clk_prev[0]) |=> $stable(s_q.mc_q[0]))
    else $error("flop moved without edge");
  a_ce_hold: assert property (!ar[0] && !ap[0] && !ctl[0].latch && ctl[0].ce_en
    && !pt[0][PT_CE] |=> $stable(s_q.mc_q[0]))
    else $error("edge not ignored");
  a_latch_pass: assert property (!ar[0] && !ap[0] && ctl[0].latch && mclk[0]
    |=> s_q.mc_q[0] == $past(xr[0]))
    else $error("latch not transparent");
  a_fuse_blocks: assert property (tck_rise && s_q.tap == TAP_CAP_DR && s_q.fuse
    && s_q.ir == IR_CFG_DATA |=> s_q.dr == '0)
    else $error("readout not blocked");
  a_sig_read: assert property (tck_rise && s_q.tap == TAP_CAP_DR && s_q.ir == IR_SIG
    |=> s_q.dr[SIG_W-1:0] == $past(s_q.sig))
    else $error("signature not captured");
  a_ir_capture: assert property (tck_rise && s_q.tap == TAP_CAP_IR
    |=> s_q.dr[IR_W-1:0] == IR_CAPTURE)
    else $error("ir capture wrong");
  a_clear_pin: assert property (ctl[0].ar_mode[0] && pins.ded[ctl[0].clr_pin]
    |=> !s_q.mc_q[0])
    else $error("clear pin ignored");
  c_cfg_write: cover property (tck_rise && s_q.tap == TAP_UPD_DR && s_q.ir == IR_CFG_DATA);
  c_ce_block: cover property (ctl[0].ce_en && !pt[0][PT_CE] && mclk[0] && !s_q.clk_prev[0]);
  c_cascade: cover property (ctl[1].cas_en && sum[0]);
  c_latch: cover property (ctl[0].latch && mclk[0]);
endmodule

//--- verif/cmrf_jtag_host.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Programming host on the four-pin test access port
// ----------------------------------------------------------------
module cmrf_jtag_host (
  // System clock, paces the test clock
  input wire logic clock,
  // Test access port
  output cmrf_pkg::cmrf_jtag_t jtag,
  input wire logic tdo
);
  import cmrf_pkg::*;

  // Test clock stands low between frames
  initial jtag = '0;

  // One test clock period, two system clocks low then two high
  task automatic tck_bit(input logic tms, input logic tdi, input logic live,
                         output logic bit_out);
    jtag.tms = tms;
    // Data line keeps moving when not shifting, so stale data never passes
    jtag.tdi = live ? tdi : ~jtag.tdi;
    repeat (2) @(negedge clock);
    // Sample before the rise, as the port answers on the fall
    bit_out = tdo;
    jtag.tck = 1'b1;
    repeat (2) @(negedge clock);
    jtag.tck = 1'b0;
  endtask

  // Leave test-logic-reset for run-test-idle
  task automatic to_idle;
    logic b;
    tck_bit(1'b0, 1'b0, 1'b0, b);
  endtask

  // Full scan from idle back to idle, data LSB first
  task automatic scan(input logic is_ir, input int len, input logic [95:0] din,
                      output logic [95:0] dout);
    logic b;
    dout = '0;
    tck_bit(1'b1, 1'b0, 1'b0, b);
    // Extra step to the instruction path
    if (is_ir) begin
      tck_bit(1'b1, 1'b0, 1'b0, b);
    end
    tck_bit(1'b0, 1'b0, 1'b0, b);
    tck_bit(1'b0, 1'b0, 1'b0, b);
    // Shift, leaving on the last bit
    for (int i = 0; i < len; i++) begin
      tck_bit(i == len - 1, din[i], 1'b1, b);
      dout[i] = b;
    end
    // Update, then the rise that leaves update lands the write
    tck_bit(1'b1, 1'b0, 1'b0, b);
    tck_bit(1'b0, 1'b0, 1'b0, b);
  endtask
endmodule

//--- verif/tb_top.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Bench for the logic fabric
// ----------------------------------------------------------------
module tb_top;
  import cmrf_pkg::*;

  // One table row: configuration and pin level beside expected outputs
  typedef struct packed {
    logic [1:0] xr;
    logic used;
    logic din;
    logic [1:0] oe;
    logic q;
    logic oe_n;
  } cmrf_case_t;

  logic clock = 1'b0;
  logic reset_n = 1'b0;
  cmrf_jtag_t jtag;
  logic tdo;
  logic tdo_oe_n;
  cmrf_pins_t pins = '0;
  logic [NUM_IO-1:0] io_out;
  logic [NUM_IO-1:0] io_oe_n;
  int errors = 0;
  int comparisons = 0;
  logic [95:0] r; // Data shifted out
  cmrf_mc_ctl_t ctl; // Control row being built
  cmrf_mc_ctl_t ctl_b; // Control row of the neighbour
  // Polarity, unused term and enable cases; aux term 4 is never used, so low
  cmrf_case_t cases [7] = '{
    '{XOR_ZERO, 1'b1, 1'b0, OE_ON, 1'b0, 1'b0},
    '{XOR_ZERO, 1'b1, 1'b1, OE_ON, 1'b1, 1'b0},
    '{XOR_ONE, 1'b1, 1'b1, OE_ON, 1'b0, 1'b0},
    '{XOR_ONE, 1'b0, 1'b1, OE_ON, 1'b1, 1'b0},
    '{XOR_ZERO, 1'b0, 1'b1, OE_OFF, 1'b0, 1'b1},
    '{XOR_ZERO, 1'b1, 1'b1, OE_PIN, 1'b1, 1'b1},
    '{2'h2, 1'b1, 1'b1, 2'h3, 1'b1, 1'b1}};

  always #5 clock = ~clock;

  cmrf_fabric dut_u (.clock(clock), .reset_n(reset_n), .jtag(jtag), .tdo(tdo),
    .tdo_oe_n(tdo_oe_n), .pins(pins), .io_out(io_out), .io_oe_n(io_oe_n));
  cmrf_jtag_host host_u (.clock(clock), .jtag(jtag), .tdo(tdo));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [95:0] got, input logic [95:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Outputs as reset leaves them: port released, every pin undriven
  task automatic check_reset;
    check(96'({tdo, tdo_oe_n, io_out, io_oe_n}), {30'h0, 2'h1, 32'h0, 32'hFFFFFFFF});
  endtask

  // Whole falling edges, inputs stay off the sampling edge
  task automatic settle(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic ir(input logic [3:0] code);
    host_u.scan(1'b1, IR_W, 96'(code), r);
  endtask

  task automatic dr(input int len, input logic [95:0] din);
    host_u.scan(1'b0, len, din, r);
  endtask

  // Point at a row, then shift it; the old row comes out in r
  task automatic row_op(input int addr, input logic [95:0] din);
    ir(IR_CFG_ADDR);
    dr(ADDR_W, 96'(addr));
    ir(IR_CFG_DATA);
    dr(ROW_W, din);
  endtask

  task automatic set_pt(input int mc, input int pt, input logic [95:0] row);
    row_op(ROW_PT_BASE + mc * PT_PER_MC + pt, row);
  endtask

  task automatic pulse_clk;
    pins.ded[0] = 1'b1;
    settle(4);
    pins.ded[0] = 1'b0;
    settle(4);
  endtask

  task automatic end_test(input string name);
    $display("done %s: %0d checks, %0d mismatches", name, comparisons, errors);
  endtask

  task automatic give_verdict;
    $display("checks=%0d mismatches=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Watchdog: the run needs about 20k clocks, allow three times that
  // ----------------------------------------------------------------
  initial begin
    #600000;
    errors++;
    give_verdict();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    settle(3);
    check_reset();
    reset_n = 1'b1;
    settle(1);
    check_reset();
    host_u.to_idle();
    // Bypass after reset: captured zero, then the first data bit
    dr(2, 96'h1);
    check(96'(r[1:0]), 96'h2);
    ir(IR_SIG);
    check(96'(r[3:0]), 96'(IR_CAPTURE));
    dr(SIG_W, 96'hA5C3);
    check(r, 96'h0);
    dr(SIG_W, 96'hA5C3);
    check(r, 96'hA5C3);
    end_test("port");
    // Table: slot 0 of block 0 takes I/O pin 0
    row_op(ROW_SW_BASE, 96'(NUM_MC + NUM_DED));
    foreach (cases[i]) begin
      set_pt(0, 0, {7'h0, cases[i].used, 88'h1});
      ctl = '0;
      ctl.or_mask = 5'h01;
      ctl.xor_src = cases[i].xr;
      ctl.comb_out = 1'b1;
      ctl.oe_mode = cases[i].oe;
      row_op(ROW_CTL_BASE, 96'(ctl));
      pins.io_in[0] = cases[i].din;
      settle(4);
      // Last two fields of a row are the expected pin level and enable
      check(96'({io_out[0], io_oe_n[0]}), 96'(cases[i][1:0]));
    end
    end_test("table");
    // Register on pin clock 0, clear from pin 1, feedback into mc 1
    row_op(ROW_SW_BASE + 1, 96'(NUM_MC + NUM_DED + 1));
    row_op(ROW_SW_BASE + 2, 96'h0);
    set_pt(0, 0, {7'h0, 1'b1, 88'h1});
    set_pt(0, PT_CE, {7'h0, 1'b1, 88'h2});
    set_pt(1, 0, {7'h0, 1'b1, 88'h4});
    ctl = '0;
    ctl.or_mask = 5'h01;
    ctl.comb_out = 1'b1;
    ctl.oe_mode = OE_ON;
    row_op(ROW_CTL_BASE + 1, 96'(ctl));
    ctl.comb_out = 1'b0;
    ctl.ar_mode = 2'h1;
    ctl.clr_pin = 2'h1;
    row_op(ROW_CTL_BASE, 96'(ctl));
    pins.io_in[0] = 1'b1;
    settle(4);
    check(96'(io_out[1:0]), 96'h0);
    pins.ded[0] = 1'b1;
    settle(4);
    check(96'(io_out[1:0]), 96'h3);
    pins.io_in[0] = 1'b0;
    settle(4);
    check(96'(io_out[1:0]), 96'h3);
    pins.ded[0] = 1'b0;
    settle(4);
    check(96'(io_out[1:0]), 96'h3);
    pins.ded[1] = 1'b1;
    settle(4);
    check(96'(io_out[1:0]), 96'h0);
    pins.ded[1] = 1'b0;
    // Clock enable from term 3, fed by I/O pin 1
    ctl.ce_en = 1'b1;
    row_op(ROW_CTL_BASE, 96'(ctl));
    pins.io_in[1:0] = 2'h1;
    pulse_clk();
    check(96'(io_out[0]), 96'h0);
    pins.io_in[1:0] = 2'h3;
    pulse_clk();
    check(96'(io_out[0]), 96'h1);
    end_test("register");
    // Latch: follows while clock high, holds while low
    ctl.ce_en = 1'b0;
    ctl.latch = 1'b1;
    row_op(ROW_CTL_BASE, 96'(ctl));
    pins.ded[0] = 1'b1;
    pins.io_in[0] = 1'b0;
    settle(4);
    check(96'(io_out[0]), 96'h0);
    pins.io_in[0] = 1'b1;
    settle(4);
    check(96'(io_out[0]), 96'h1);
    pins.ded[0] = 1'b0;
    settle(2);
    pins.io_in[0] = 1'b0;
    settle(4);
    check(96'(io_out[0]), 96'h1);
    end_test("latch");
    // Foldback of mc 0 feeds term 1 of mc 1, then mc 0's sum cascades up
    set_pt(1, 1, {7'h0, 1'b1, 88'h10000000000});
    ctl_b = '0;
    ctl_b.or_mask = 5'h02;
    ctl_b.comb_out = 1'b1;
    ctl_b.oe_mode = OE_ON;
    row_op(ROW_CTL_BASE + 1, 96'(ctl_b));
    pins.io_in[0] = 1'b1;
    settle(4);
    check(96'(io_out[1]), 96'h0);
    pins.io_in[0] = 1'b0;
    settle(4);
    check(96'(io_out[1]), 96'h1);
    ctl_b.or_mask = 5'h00;
    ctl_b.cas_en = 1'b1;
    row_op(ROW_CTL_BASE + 1, 96'(ctl_b));
    settle(2);
    check(96'(io_out[1]), 96'h0);
    pins.io_in[0] = 1'b1;
    settle(4);
    check(96'(io_out[1]), 96'h1);
    end_test("chain");
    // Readback, then fuse, then erase
    row_op(ROW_CTL_BASE, 96'(ctl));
    check(r, 96'(ctl));
    ir(IR_FUSE);
    dr(1, 96'h1);
    row_op(ROW_CTL_BASE, 96'(ctl));
    check(r, 96'h0);
    ir(IR_SIG);
    dr(SIG_W, 96'hA5C3);
    check(r, 96'hA5C3);
    ir(IR_ERASE);
    dr(1, 96'h0);
    settle(4);
    check(96'(io_oe_n[0]), 96'h1);
    // Erased row reads empty, and with the fuse gone a write reads back
    row_op(ROW_CTL_BASE, 96'(ctl));
    check(r, 96'h0);
    row_op(ROW_CTL_BASE, 96'h0);
    check(r, 96'(ctl));
    ir(IR_SIG);
    dr(SIG_W, 96'hA5C3);
    check(r, 96'hA5C3);
    end_test("security");
    // Reset in mid-run releases every pin and clears the signature
    reset_n = 1'b0;
    settle(2);
    check_reset();
    reset_n = 1'b1;
    settle(1);
    check_reset();
    host_u.to_idle();
    ir(IR_SIG);
    dr(SIG_W, 96'h0);
    check(r, 96'h0);
    end_test("reset");
    give_verdict();
  end
endmodule
